/* File: hw/txof_top.sv */
// Our own choice: the APB register port.
`timescale 1ns/1ps
module txof_top (
  // clock, enable and reset
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic reset,
  // apb slave
  input wire txof_pkg::txof_apb_type apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // summing chain samples, same clock
  input wire txof_pkg::txof_bus_type chain_i,
  input wire txof_pkg::txof_bus_type chain_q,
  input wire logic sample_vld,
  // meter start sources
  input wire logic tx_sync,
  input wire logic interval_start,
  // test slice data
  input wire txof_pkg::txof_slice_type slice_data,
  // transmit outputs
  output txof_pkg::txof_bus_type tx_bus,
  output logic tx_iflag,
  output logic test_clk_out,
  output logic [txof_pkg::DATA_W-1:0] test_data_out,
  // interrupt
  output logic irq
);
  import txof_pkg::*;

  // whole state of the block
  typedef struct packed {
    // control page fields, owned by software
    logic [2:0] slice_sel;
    logic [1:0] round_pt;
    logic [3:0] ena;
    logic interl;
    logic real_sel;
    // gain nibbles, one per summing chain
    logic [N_CHAIN-1:0][3:0] scale;
    // meter set-up: count halves and start delay
    logic [15:0] cnt_lo;
    logic [4:0] cnt_hi;
    logic [8:0] delay;
    // test clock divide setting
    logic [4:0] rate;
    // interrupt mask and sticky status
    logic [3:0] mask;
    logic [3:0] status;
    // meter: published result, running sum, sample and delay counts
    logic [ACC_W-1:0] result;
    logic [ACC_W-1:0] acc;
    logic [CNT_W-1:0] nsamp;
    logic [DLY_W-1:0] dly_cnt;
    txof_pm_type pm;
    // test clock divider
    logic [4:0] tclk_cnt;
    logic tclk;
    // registered stream outputs
    txof_bus_type bus;
    logic iq_phase;
    logic iflag;
    logic [DATA_W-1:0] test_data;
    // apb answer: ready and error held for one cycle only, read data until the next setup
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic irq;
    // sync pin synchroniser and edge history
    logic sync_meta;
    logic sync_sync;
    logic sync_prev;
  } txof_state_type;

  txof_state_type st_ff;   // registered state
  txof_state_type nxt_st;  // next state

  txof_bus_type fmt_i;     // formatted I per chain
  txof_bus_type fmt_q;     // formatted Q per chain

  // gain, round and limit one sample
  function automatic logic [DATA_W-1:0] fmt_sample(
    input logic [DATA_W-1:0] x,
    input logic [3:0] sh,
    input logic [1:0] rp
  );
    logic signed [EXT_W-1:0] v;
    logic signed [EXT_W-1:0] hi;
    logic signed [EXT_W-1:0] lo;
    logic [4:0] drop;
    // headroom: 18 bits shifted by 15 plus the round term fit in 36,
    // so the saturation compare never sees a wrapped value
    drop = {2'h0, rp, 1'b0};
    v = {{(EXT_W-DATA_W){x[DATA_W-1]}}, x};
    v = v <<< sh;
    if (drop != 5'h00) begin
      v = v + (36'sh1 <<< (drop - 5'h01));
    end
    v = v >>> drop;
    hi = (36'sh1 <<< (5'h11 - drop)) - 36'sh1;
    lo = -hi - 36'sh1;
    if (v > hi) begin
      v = hi;
    end else if (v < lo) begin
      v = lo;
    end
    v = v <<< drop;
    return v[DATA_W-1:0];
  endfunction

  // per chain formatting; output and meter see the same value
  genvar g;
  generate
    for (g = 0; g < N_CHAIN; g++) begin : g_chain
      assign fmt_i[g] = fmt_sample(chain_i[g], st_ff.scale[g],
        st_ff.round_pt);
      assign fmt_q[g] = fmt_sample(chain_q[g], st_ff.scale[g],
        st_ff.round_pt);
    end
  endgenerate

  // meter inputs: chain 0 squared sum
  logic signed [DATA_W-1:0] pm_i;
  logic signed [DATA_W-1:0] pm_q;
  logic [2*DATA_W:0] pm_sq;
  logic [CNT_W-1:0] pm_total;
  logic pm_last;
  logic sync_edge;
  logic setup;
  logic done_wr;
  logic done_rd;
  logic mapped;
  logic [7:0] idx;
  assign pm_i = fmt_i[0];
  assign pm_q = fmt_q[0];
  assign pm_sq = (2*DATA_W+1)'(pm_i * pm_i) + (2*DATA_W+1)'(pm_q * pm_q);
  assign pm_total = {st_ff.cnt_hi, st_ff.cnt_lo};
  // a zero count behaves as one so the meter always completes
  assign pm_last = (st_ff.nsamp + 21'h000001 >= pm_total);
  assign sync_edge = st_ff.sync_sync & ~st_ff.sync_prev;
  // setup is ignored while ready stands, so a held request is never
  // mistaken for a second access
  assign setup = apb.psel & ~apb.penable & ~st_ff.rdy;
  assign done_wr = apb.psel & apb.penable & st_ff.rdy & apb.pwrite;
  assign done_rd = apb.psel & apb.penable & st_ff.rdy & ~apb.pwrite;
  // word index; the two low address bits must be zero
  assign idx = {2'h0, apb.paddr[7:2]};
  assign mapped = (apb.paddr[1:0] == 2'h0) &&
    (idx == IDX_CTRL || idx == IDX_SCALE || idx == IDX_CNT_LO ||
     idx == IDX_CNT_HI || idx == IDX_TCLK || idx == IDX_RES_LO ||
     idx == IDX_RES_HI || idx == IDX_STATUS || idx == IDX_MASK);

  // next state: bus access, then datapath, test clock and meter
  always_comb begin
    logic [3:0] st_set;
    logic [3:0] st_clr;
    st_set = 4'h0;
    st_clr = 4'h0;
    nxt_st = st_ff;
    // pin synchroniser; only the second stage is looked at
    nxt_st.sync_meta = tx_sync;
    nxt_st.sync_sync = st_ff.sync_meta;
    nxt_st.sync_prev = st_ff.sync_sync;
    // one access cycle: ready rises the cycle after setup
    nxt_st.rdy = setup;
    nxt_st.err = setup & ~mapped;
    if (setup) begin
      case (idx)
        IDX_CTRL: nxt_st.rdata = {16'h0, st_ff.slice_sel, 3'h0,
          st_ff.round_pt, st_ff.ena, 2'h0, st_ff.interl, st_ff.real_sel};
        IDX_SCALE: nxt_st.rdata = {16'h0, st_ff.scale};
        IDX_CNT_LO: nxt_st.rdata = {16'h0, st_ff.cnt_lo};
        IDX_CNT_HI: nxt_st.rdata = {16'h0, st_ff.delay, 2'h0,
          st_ff.cnt_hi};
        IDX_TCLK: nxt_st.rdata = {16'h0, st_ff.rate, 11'h0};
        IDX_RES_LO: nxt_st.rdata = st_ff.result[31:0];
        IDX_RES_HI: nxt_st.rdata = st_ff.result[63:32];
        IDX_STATUS: nxt_st.rdata = {16'h0, st_ff.status, 12'h0};
        IDX_MASK: nxt_st.rdata = {16'h0, st_ff.mask, 12'h0};
        default: nxt_st.rdata = 32'h0;
      endcase
    end
    // write takes effect only at the completing edge
    if (done_wr) begin
      case (idx)
        IDX_CTRL: begin
          nxt_st.slice_sel = apb.pwdata[POS_SLICE+:3];
          nxt_st.round_pt = apb.pwdata[POS_ROUND+:2];
          nxt_st.ena = apb.pwdata[POS_ENA+:4];
          nxt_st.interl = apb.pwdata[POS_INTERL];
          nxt_st.real_sel = apb.pwdata[POS_REAL];
        end
        IDX_SCALE: nxt_st.scale = apb.pwdata[15:0];
        IDX_CNT_LO: nxt_st.cnt_lo = apb.pwdata[15:0];
        IDX_CNT_HI: begin
          nxt_st.cnt_hi = apb.pwdata[4:0];
          nxt_st.delay = apb.pwdata[POS_DELAY+:9];
        end
        IDX_TCLK: nxt_st.rate = apb.pwdata[POS_RATE+:5];
        IDX_MASK: nxt_st.mask = apb.pwdata[POS_IRQ+:4];
        default: ;
      endcase
    end
    // reading status clears it
    if (done_rd && idx == IDX_STATUS) begin
      st_clr = 4'hF;
    end

    // output buses
    // real: bus n carries I of chain n; complex: even buses I and odd
    // buses Q of chains 0 and 1; interleaved: each bus alternates I, Q
    // of its own chain, with the flag marking the I word
    nxt_st.iq_phase = st_ff.interl ? ~st_ff.iq_phase : 1'b0;
    nxt_st.iflag = st_ff.interl & ~st_ff.real_sel & ~st_ff.iq_phase;
    for (int n = 0; n < N_CHAIN; n++) begin
      logic [DATA_W-1:0] v;
      v = fmt_i[n];
      if (!st_ff.real_sel) begin
        if (st_ff.interl) begin
          // bus n alternates I then Q of chain n
          v = st_ff.iq_phase ? fmt_q[n] : fmt_i[n];
        end else if (n[0]) begin
          v = fmt_q[n/2];
        end else begin
          v = fmt_i[n/2];
        end
      end
      nxt_st.bus[n] = st_ff.ena[n] ? v : '0;
    end

    // test slice mux
    nxt_st.test_data = slice_data[st_ff.slice_sel];

    // test clock: high for the first half of 1 + rate cycles
    if (st_ff.tclk_cnt >= st_ff.rate) begin
      nxt_st.tclk_cnt = 5'h00;
    end else begin
      nxt_st.tclk_cnt = st_ff.tclk_cnt + 5'h01;
    end
    // high while the count sits in the first ceil half of the period;
    // rate zero keeps the count at zero, so the pin simply stays high
    nxt_st.tclk = (nxt_st.tclk_cnt <= (st_ff.rate >> 1));

    // power meter
    // only chain 0 is measured; a start event of either kind restarts
    // a measurement in flight, so software must not rely on finishing
    // one when starts arrive faster than the count
    case (st_ff.pm)
      PM_DELAY: begin
        if (sample_vld) begin
          if (st_ff.dly_cnt <= 12'h001) begin
            nxt_st.pm = PM_ACCUM;
          end else begin
            nxt_st.dly_cnt = st_ff.dly_cnt - 12'h001;
          end
        end
      end
      PM_ACCUM: begin
        if (sample_vld) begin
          nxt_st.acc = st_ff.acc + ACC_W'(pm_sq);
          nxt_st.nsamp = st_ff.nsamp + 21'h000001;
          if (pm_last) begin
            // whole word set in one edge, never a mixture
            nxt_st.result = st_ff.acc + ACC_W'(pm_sq);
            st_set[0] = 1'b1;
            nxt_st.pm = PM_IDLE;
          end
        end
      end
      PM_IDLE: ;
      default: nxt_st.pm = PM_IDLE;
    endcase
    // start events restart the measurement
    if (interval_start) begin
      nxt_st.pm = PM_ACCUM;
      nxt_st.acc = '0;
      nxt_st.nsamp = '0;
    end else if (sync_edge) begin
      nxt_st.acc = '0;
      nxt_st.nsamp = '0;
      nxt_st.dly_cnt = DLY_W'(st_ff.delay) * DELAY_UNIT;
      nxt_st.pm = (st_ff.delay == 9'h000) ? PM_ACCUM : PM_DELAY;
    end
    // hardware set wins over the read clear
    nxt_st.status = (st_ff.status & ~st_clr) | st_set;
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  // state register; clock enable freezes everything
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.ena <= RST_ENA;
      st_ff.real_sel <= RST_REAL;
      st_ff.pm <= PM_IDLE;
      st_ff.tclk <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign prdata = st_ff.rdata;
  assign pready = st_ff.rdy;
  assign pslverr = st_ff.err;
  assign tx_bus = st_ff.bus;
  assign tx_iflag = st_ff.iflag;
  assign test_clk_out = st_ff.tclk;
  assign test_data_out = st_ff.test_data;
  assign irq = st_ff.irq;

  // registered test clock, named so the checks can watch its edges
  logic tclk_w;
  assign tclk_w = st_ff.tclk;

  // checks
  a_bus_disabled: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !st_ff.ena[1] |=> tx_bus[1] == '0)
    else $error("disabled bus not zero");
  a_low_bits_zero: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && st_ff.round_pt == 2'h3 |=> tx_bus[0][5:0] == 6'h00)
    else $error("low bits not zero at 12 bit round");
  a_real_passes_i: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && st_ff.real_sel && st_ff.ena[2]
    |=> tx_bus[2] == $past(fmt_i[2]))
    else $error("real mode bus not I");
  a_interl_swap: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && st_ff.interl && !st_ff.real_sel && st_ff.iq_phase
    && st_ff.ena[0] |=> tx_bus[0] == $past(fmt_q[0]))
    else $error("interleave did not present Q");
  // four or more at full gain always overflows the 12 bit range
  a_sat_positive: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && st_ff.round_pt == 2'h3 && st_ff.ena[0] && st_ff.real_sel
    && !chain_i[0][17] && st_ff.scale[0] == 4'hF && chain_i[0] > 18'h00003
    |=> tx_bus[0] == 18'h1FFC0)
    else $error("no positive saturation");
  a_tclk_half: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && st_ff.rate == 5'h01 && $stable(st_ff.rate) && $rose(tclk_w)
    |=> !test_clk_out)
    else $error("test clock period wrong");
  a_done_irq: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && st_ff.pm == PM_ACCUM && sample_vld && pm_last
    && !interval_start && !sync_edge && st_ff.mask[0]
    |=> st_ff.status[0] && irq && st_ff.pm == PM_IDLE)
    else $error("completion not flagged");
  a_result_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !(st_ff.pm == PM_ACCUM && sample_vld) |=> $stable(st_ff.result))
    else $error("result changed outside completion");
  a_delay_entry: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && sync_edge && !interval_start && st_ff.delay == 9'h002
    |=> st_ff.pm == PM_DELAY && st_ff.dly_cnt == 12'h010)
    else $error("sync delay not loaded");
  a_slice_mux: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en |=> test_data_out == $past(slice_data[st_ff.slice_sel]))
    else $error("test slice mux wrong");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (reset)
    irq == |(st_ff.status & st_ff.mask))
    else $error("interrupt not gated by mask");
  // main scenarios: a full measurement, a delayed sync start, interleave
  c_measure: cover property (@(posedge sys_clk) disable iff (reset)
    st_ff.pm == PM_ACCUM ##1 st_ff.status[0]);
  c_delay: cover property (@(posedge sys_clk) disable iff (reset)
    st_ff.pm == PM_DELAY ##1 st_ff.pm == PM_ACCUM);
  c_interl: cover property (@(posedge sys_clk) disable iff (reset)
    tx_iflag ##1 !tx_iflag);
  // sync edge followed by the delay phase
  c_sync_delay: cover property (@(posedge sys_clk) disable iff (reset)
    sync_edge ##1 st_ff.pm == PM_DELAY);
  // interrupt up then down, by a status read clear or a mask write
  c_irq_clear: cover property (@(posedge sys_clk) disable iff (reset)
    irq ##1 !irq);
endmodule

/* File: hw/txof_pkg.sv */
package txof_pkg;
  localparam int DATA_W = 18;              // sample and bus width
  localparam int N_CHAIN = 4;              // summing chains and buses
  localparam int N_SLICE = 8;              // test slices
  localparam int EXT_W = 36;               // headroom for gain and round
  localparam int ACC_W = 64;               // power accumulator width
  localparam int CNT_W = 21;               // integration count width
  localparam int DLY_W = 12;               // delay in samples
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_SCALE = 8'h01;
  localparam logic [7:0] IDX_CNT_LO = 8'h02;
  localparam logic [7:0] IDX_CNT_HI = 8'h03;
  localparam logic [7:0] IDX_TCLK = 8'h05;
  localparam logic [7:0] IDX_RES_LO = 8'h08;
  localparam logic [7:0] IDX_RES_HI = 8'h09;
  localparam logic [7:0] IDX_STATUS = 8'h0A;
  localparam logic [7:0] IDX_MASK = 8'h29;
  // field positions
  localparam int POS_SLICE = 13;
  localparam int POS_ROUND = 8;
  localparam int POS_ENA = 4;
  localparam int POS_INTERL = 1;
  localparam int POS_REAL = 0;
  localparam int POS_DELAY = 7;
  localparam int POS_RATE = 11;
  localparam int POS_IRQ = 12;
  // reset values and the delay step
  localparam logic [3:0] RST_ENA = 4'hF;
  localparam logic RST_REAL = 1'b1;
  localparam logic [DLY_W-1:0] DELAY_UNIT = 12'h008;
  typedef logic [N_CHAIN-1:0][DATA_W-1:0] txof_bus_type;
  typedef logic [N_SLICE-1:0][DATA_W-1:0] txof_slice_type;
  typedef enum logic [1:0] {
    PM_IDLE = 2'b00,
    PM_DELAY = 2'b01,
    PM_ACCUM = 2'b10
  } txof_pm_type;
  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } txof_apb_type;
endpackage

/* File: dv/txof_dac_sink.sv */
`timescale 1ns/1ps
// far-side sink: takes every lane 0 word like a converter input latch
module txof_dac_sink (
  // clock
  input wire logic sys_clk,
  // formatted stream from the block
  input wire txof_pkg::txof_bus_type tx_bus,
  input wire logic tx_iflag,
  // count of interleaved in-phase words taken
  output logic [31:0] words_seen
);
  import txof_pkg::*;
  logic [DATA_W-1:0] held_ff;  // last lane 0 word, as a converter holds it
  initial words_seen = 32'h0;
  // a converter only latches; it never pushes back on the stream
  always @(posedge sys_clk) begin
    held_ff <= tx_bus[0];
    if (tx_iflag === 1'b1) begin
      words_seen <= words_seen + 32'h1;
    end
  end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import txof_pkg::*;
  logic sys_clk, reset, clk_en, pready, pslverr, sample_vld, tx_sync;
  logic interval_start, tx_iflag, test_clk_out, irq, err, prev;
  logic [31:0] prdata, rd, rng, r;
  txof_apb_type apb_r;  // request bundle held by the master
  txof_bus_type chain_i, chain_q, tx_bus;
  txof_slice_type slice_data;
  logic [DATA_W-1:0] test_data_out;
  int n_errors, samples_checked;
  longint iv[4], qv[4];  // signed chain samples as driven
  txof_top dut_u (.sys_clk(sys_clk), .clk_en(clk_en), .reset(reset),
    .apb(apb_r), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chain_i(chain_i), .chain_q(chain_q), .sample_vld(sample_vld),
    .tx_sync(tx_sync), .interval_start(interval_start),
    .slice_data(slice_data), .tx_bus(tx_bus), .tx_iflag(tx_iflag),
    .test_clk_out(test_clk_out), .test_data_out(test_data_out), .irq(irq));
  txof_dac_sink sink_u (.sys_clk(sys_clk), .tx_bus(tx_bus),
    .tx_iflag(tx_iflag), .words_seen());
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // reference formatter: scale, round half up, saturate, msb justify
  function automatic longint fmt(longint x, int sh, int rp);
    int d;
    longint w, mx;
    d = 2 * rp;
    w = x <<< sh;
    if (d > 0) w = w + (longint'(1) <<< (d - 1));
    w = w >>> d;
    mx = (longint'(1) <<< (17 - d)) - 1;
    if (w > mx) w = mx;
    if (w < -mx - 1) w = -mx - 1;
    return w <<< d;
  endfunction
  // expected word on bus n for control word c
  function automatic logic [17:0] exp_bus(int n, logic [15:0] c, int sc,
                                          logic iq);
    longint v;
    if (!c[POS_ENA+n]) return 18'h00000;
    if (c[POS_REAL]) v = iv[n];
    else if (c[POS_INTERL]) v = iq ? iv[n] : qv[n];
    else v = (n % 2 == 0) ? iv[n/2] : qv[n/2];
    return 18'(fmt(v, sc, int'(c[9:8])));
  endfunction
  // xorshift source, fixed start
  function logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    apb_r <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apb_r.penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    if (n == 50) n_errors++;
    apb_r <= '0;
  endtask
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(nm, {32'h0, exp}, {32'h0, rd});
  endtask
  task close_out();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    #400000;
    n_errors++;
    close_out();
  end
  initial begin
    int sc, m, cyc, lo, hi, rises, highs;
    logic [15:0] c;
    logic [63:0] res;
    rng = 32'h0000003D;
    n_errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    apb_r = '0;
    chain_i = '0;
    chain_q = '0;
    slice_data = '0;
    sample_vld = 1'b0;
    tx_sync = 1'b0;
    interval_start = 1'b0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    // reset values, refusals, field read back
    rd_chk("ctrl", 8'h00, 32'h000000F1);
    rd_chk("scale", 8'h04, 32'h00000000);
    bus(1'b0, 8'h40, 32'h00000000);
    chk("unmapped", 64'h1, {63'h0, err});
    bus(1'b0, 8'h02, 32'h00000000);
    chk("unaligned", 64'h1, {63'h0, err});
    bus(1'b1, 8'h08, 32'h0000A5C3);
    rd_chk("count_lo", 8'h08, 32'h0000A5C3);
    bus(1'b1, 8'h0C, 32'h0000FF9F);
    rd_chk("count_hi", 8'h0C, 32'h0000FF9F);
    // data path: every round point in real, complex and interleaved
    for (int t = 0; t < 12; t++) begin
      sc = xs() % 6;
      r = xs();
      c = 16'h0000;
      c[9:8] = 2'(t % 4);
      c[7:4] = (t < 8) ? 4'hF : r[3:0];
      c[1] = (t >= 8);
      c[0] = (t < 4);
      bus(1'b1, 8'h04, {16'h0000, {4{4'(sc)}}});
      bus(1'b1, 8'h00, {16'h0000, c});
      for (int n = 0; n < 4; n++) begin
        r = xs();
        chain_i[n] <= r[17:0];
        iv[n] = longint'($signed(r[17:0]));
        r = xs();
        chain_q[n] <= r[17:0];
        qv[n] = longint'($signed(r[17:0]));
      end
      for (int k = 0; k < 2; k++) begin
        @(posedge sys_clk);
        #1;
        if (k == 1 && c[1]) chk("iflag", {63'h0, ~prev}, {63'h0, tx_iflag});
        prev = tx_iflag;
        for (int n = 0; n < 4; n++) begin
          chk("tx_bus", exp_bus(n, c, sc, tx_iflag), tx_bus[n]);
        end
      end
    end
    // test slice selection
    for (int s = 0; s < 8; s++) begin
      r = xs();
      bus(1'b1, 8'h00, {16'h0000, 3'(s), 13'h00F1});
      slice_data[s] <= r[17:0];
      repeat (2) @(posedge sys_clk);
      #1;
      chk("test_data", {46'h0, r[17:0]}, {46'h0, test_data_out});
    end
    // test clock: four whole periods for rates 0 to 3 and 31
    for (int k = 0; k < 5; k++) begin
      m = (k < 4) ? k : 31;
      bus(1'b1, 8'h14, 32'(m << 11));
      repeat (3 * (m + 1)) @(posedge sys_clk);
      #1;
      prev = test_clk_out;
      rises = 0;
      highs = 0;
      repeat (4 * (m + 1)) begin
        @(posedge sys_clk);
        #1;
        highs += int'(test_clk_out);
        rises += int'(test_clk_out && !prev);
        prev = test_clk_out;
      end
      chk("clk_highs", 64'(4 * ((m + 2) / 2)), 64'(highs));
      if (m > 0) chk("clk_rises", 64'h4, 64'(rises));
    end
    // meter: interval start, masked run, sync with delay
    bus(1'b1, 8'h04, 32'h00000000);
    bus(1'b1, 8'h00, 32'h000000F1);
    r = xs();
    chain_i[0] <= r[17:0];
    iv[0] = longint'($signed(r[17:0]));
    r = xs();
    chain_q[0] <= r[17:0];
    qv[0] = longint'($signed(r[17:0]));
    for (int k = 0; k < 3; k++) begin
      m = (k == 0) ? 3 : k;
      bus(1'b1, 8'hA4, (k == 1) ? 32'h00000000 : 32'h00001000);
      // no restart interval here; the count alone ends a run
      bus(1'b1, 8'h08, 32'(m));
      bus(1'b1, 8'h0C, (k == 2) ? 32'h00000100 : 32'h00000000);
      if (k == 2) tx_sync <= 1'b1;
      else interval_start <= 1'b1;
      @(posedge sys_clk);
      interval_start <= 1'b0;
      sample_vld <= 1'b1;
      cyc = 0;
      while (irq !== 1'b1 && cyc < 40) begin
        @(posedge sys_clk);
        #1;
        cyc++;
      end
      sample_vld <= 1'b0;
      tx_sync <= 1'b0;
      lo = m + ((k == 2) ? 16 : 0);
      hi = lo + ((k == 2) ? 5 : 1);
      if (k == 1) lo = 40;
      if (k == 1) hi = 40;
      chk("irq_time", 64'h1, {63'h0, cyc >= lo && cyc <= hi});
      res = 64'((iv[0] * iv[0] + qv[0] * qv[0]) * m);
      rd_chk("result_lo", 8'h20, res[31:0]);
      rd_chk("result_hi", 8'h24, res[63:32]);
      rd_chk("status", 8'h28, 32'h00001000);
      rd_chk("status_clr", 8'h28, 32'h00000000);
      #1;
      chk("irq_clr", 64'h0, {63'h0, irq});
    end
    close_out();
  end
endmodule
